// ===== hw/acs_fifo.sv
// flip-flop fifo holding conversion results until read
`timescale 1ns/1ps
`default_nettype none
module acs_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem_q[rdPtr_q];

    always_ff @(posedge sys_clk) begin
        if (doPush) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doPush) wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            if (doPop)  rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule
`default_nettype wire

// ===== hw/acs_seq.sv
// conversion sequencer with parallel read/write port and first-result flag
// How it works
// - external timing: conversion lasts 13 input cycles
// - internal timing: conversion within 1.65 us
// - busy spans channels times conv+pulse, less pulse
// - busy rises within 70 ns of start
// - read strobe rise updates first flag quickly
// - end-of-conversion fall drops first flag quickly unless a read strobe rise in the same cycle updates it
// - channel select captured on write strobe rise
// - start edge holds samples, latches selection, converts
// - first flag high while pointer at first result; set only by a read that wraps the pointer
// - write with select low loads low bus bits
`timescale 1ns/1ps
`default_nettype none
`include "acs_cfg.svh"
module acs_seq (
    // clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           reset,
    // conversion control
    input  wire logic                           conversionStart,
    input  wire logic                           lowPowerInput,
    input  wire logic                           externalTimingInput,
    input  wire logic                           useExternalTiming,
    input  wire logic                           hwSequenceSelect,
    input  wire logic [`ACS_SEL_W-1:0]          hwChannelSelect,
    input  wire acs_pkg::acs_samples_t          analogSamples,
    // parallel bus
    input  wire logic                           chipSelectN,
    input  wire logic                           readN,
    input  wire logic                           writeN,
    input  wire logic [`ACS_DATA_W-1:0]         busIn,
    output logic      [`ACS_DATA_W-1:0]         busOut,
    output logic                                busOe,
    // status
    output logic                                busy,
    output logic                                endOfConvN,
    output logic                                firstResultFlag
);
    import acs_pkg::*;

    localparam int INT_CYC = `ACS_TCONV_INT_CYC;
    localparam int EOC_CYC = `ACS_EOC_CYC;

    // lowest selected channel still pending
    function automatic logic [1:0] lowestChan(input logic [`ACS_SEL_W-1:0] m);
        lowestChan = 2'h0;
        for (int i = `ACS_SEL_W - 1; i >= 0; i--) begin
            if (m[i]) lowestChan = 2'(i);
        end
    endfunction

    acs_state_t             state_q;
    acs_state_t             state_d;
    logic [7:0]             cycCnt_q;
    logic [3:0]             extCnt_q;
    logic [3:0]             eocCnt_q;
    logic                   extMode_q;
    logic [`ACS_SEL_W-1:0]  pending_q;
    logic [`ACS_SEL_W-1:0]  latchedSel_q;
    logic [`ACS_SEL_W-1:0]  chanSel_q;
    acs_samples_t           held_q;
    logic                   startPrev_q;
    logic                   extPrev_q;
    logic                   readPrev_q;
    logic                   writePrev_q;
    logic                   readCs_q;
    logic [1:0]             rdPtr_q;
    logic                   flag_q;
    logic [`ACS_DATA_W-1:0] busOut_q;
    logic                   fifoInReady;
    logic                   fifoOutValid;
    logic [13:0]            fifoOutData;
    acs_result_t            headResult;
    acs_result_t            newResult;

    // edge decoding
    wire                    startRise   = conversionStart && !startPrev_q;
    wire                    extTick     = externalTimingInput && !extPrev_q;
    wire                    readFall    = !readN && readPrev_q;
    wire                    readRise    = readN && !readPrev_q;
    wire                    writeRise   = writeN && !writePrev_q;
    wire [`ACS_SEL_W-1:0]   selNow      = hwSequenceSelect ? hwChannelSelect : chanSel_q;
    wire                    startAccept = startRise && (state_q == ST_IDLE) && lowPowerInput && (selNow != '0);
    wire [1:0]              curChan     = lowestChan(pending_q);
    wire [`ACS_SEL_W-1:0]   curBit      = `ACS_SEL_W'(1) << curChan;
    wire                    intDone     = (cycCnt_q >= 8'(INT_CYC - 1));
    wire                    extDone     = extTick && (extCnt_q == 4'(`ACS_EXT_CONV_TICKS - 1));
    wire                    convDone    = (state_q == ST_CONV) && (extMode_q ? extDone : intDone) && fifoInReady;
    wire                    lastChan    = ((pending_q & ~curBit) == '0);
    wire                    eocEnd      = (state_q == ST_EOC) && (eocCnt_q == 4'(EOC_CYC - 1));
    wire                    eocFall     = convDone;
    wire                    writeAccept = writeRise && !chipSelectN && readN;
    wire                    popResult   = readRise && readCs_q && fifoOutValid;
    wire [1:0]              numSel      = 2'(latchedSel_q[0] + latchedSel_q[1] + latchedSel_q[2] + latchedSel_q[3] - 1);
    wire [1:0]              rdPtrNext   = (rdPtr_q == numSel) ? 2'h0 : rdPtr_q + 2'h1;

    assign newResult  = '{chan: curChan, data: held_q[curChan]};
    assign headResult = acs_result_t'(fifoOutData);

    // state sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (startAccept) state_d = ST_CONV;
            ST_CONV: if (convDone) state_d = ST_EOC;
            ST_EOC:  if (eocEnd) state_d = (pending_q == '0) ? ST_IDLE : ST_CONV;
            default: state_d = ST_IDLE;
        endcase
    end

    // busy drops as the last pulse begins
    assign busy       = (state_q == ST_CONV) || ((state_q == ST_EOC) && (pending_q != '0));
    assign endOfConvN = (state_q != ST_EOC);
    assign busOe      = !chipSelectN && !readN;
    assign busOut     = busOut_q;
    assign firstResultFlag = flag_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q     <= ST_IDLE;
            startPrev_q <= 1'b0;
            extPrev_q   <= 1'b0;
            readPrev_q  <= 1'b1;
            writePrev_q <= 1'b1;
        end else begin
            state_q     <= state_d;
            startPrev_q <= conversionStart;
            extPrev_q   <= externalTimingInput;
            readPrev_q  <= readN;
            writePrev_q <= writeN;
        end
    end

    // conversion timing counters
    always_ff @(posedge sys_clk) begin
        if (reset || state_q != ST_CONV) begin
            cycCnt_q <= '0;
            extCnt_q <= '0;
        end else begin
            if (!intDone) cycCnt_q <= cycCnt_q + 8'h01;
            if (extTick && !extDone) extCnt_q <= extCnt_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || state_q != ST_EOC) begin
            eocCnt_q <= '0;
        end else begin
            eocCnt_q <= eocCnt_q + 4'h1;
        end
    end

    // selection latch and pending mask
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pending_q    <= '0;
            latchedSel_q <= '0;
            extMode_q    <= 1'b0;
        end else if (startAccept) begin
            pending_q    <= selNow;
            latchedSel_q <= selNow;
            extMode_q    <= useExternalTiming;
        end else if (convDone) begin
            pending_q    <= pending_q & ~curBit;
        end
    end

    // track-and-hold per channel
    generate
        for (genvar g = 0; g < `ACS_NUM_CH; g++) begin : g_hold
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    held_q[g] <= '0;
                end else if (startAccept) begin
                    held_q[g] <= analogSamples[g];
                end
            end
        end
    endgenerate

    // channel select register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            chanSel_q <= '0;
        end else if (writeAccept) begin
            chanSel_q <= busIn[`ACS_SEL_LSB +: `ACS_SEL_W];
        end
    end

    // read port and result pointer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            readCs_q <= 1'b0;
            busOut_q <= '0;
            rdPtr_q  <= '0;
            flag_q   <= 1'b0;
        end else begin
            if (readFall) begin
                readCs_q <= !chipSelectN && fifoOutValid;
                busOut_q <= fifoOutValid ? headResult.data : '0;
            end
            if (startAccept) rdPtr_q <= '0;
            else if (popResult) rdPtr_q <= rdPtrNext;
            if (popResult) flag_q <= (rdPtrNext == 2'h0);
            else if (eocFall) flag_q <= 1'b0;
        end
    end

    acs_fifo #(
        .WIDTH ($bits(acs_result_t)),
        .DEPTH (`ACS_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .inValid  (convDone),
        .inReady  (fifoInReady),
        .inData   (newResult),
        .outValid (fifoOutValid),
        .outReady (popResult),
        .outData  (fifoOutData)
    );

    a_busy_rises: assert property (@(posedge sys_clk) disable iff (reset)
        startAccept |=> busy) else $error("busy late after start");
    a_sel_latch: assert property (@(posedge sys_clk) disable iff (reset)
        startAccept |=> pending_q == $past(selNow)) else $error("selection not latched");
    a_ext_conv_len: assert property (@(posedge sys_clk) disable iff (reset)
        convDone && extMode_q |-> extTick && extCnt_q == 4'd12) else $error("external conversion not 13 ticks");
    a_int_conv_len: assert property (@(posedge sys_clk) disable iff (reset)
        convDone && !extMode_q |-> cycCnt_q == 8'd164) else $error("internal conversion not 165 cycles");
    a_eoc_width: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(endOfConvN) |-> (!endOfConvN)[*8] ##1 endOfConvN) else $error("pulse width wrong");
    a_busy_falls: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(busy) |-> !endOfConvN && state_q == ST_EOC) else $error("busy fell outside last pulse");
    a_flag_read: assert property (@(posedge sys_clk) disable iff (reset)
        popResult |=> firstResultFlag == (rdPtr_q == 2'h0)) else $error("flag not updated on read");
    a_flag_eoc: assert property (@(posedge sys_clk) disable iff (reset)
        eocFall && !popResult |=> !firstResultFlag && !endOfConvN) else $error("flag not cleared on pulse");
    a_chan_write: assert property (@(posedge sys_clk) disable iff (reset)
        writeAccept |=> chanSel_q == $past(busIn[3:0])) else $error("channel select not written");

    c_four_chan: cover property (@(posedge sys_clk) startAccept && selNow == 4'hF);
    c_ext_conv: cover property (@(posedge sys_clk) convDone && extMode_q);
    c_sel_write: cover property (@(posedge sys_clk) writeAccept);
    c_flag_high: cover property (@(posedge sys_clk) popResult ##1 firstResultFlag);
endmodule
`default_nettype wire

// ===== shared/acs_cfg.svh
// timing counts and field positions for the conversion sequencer
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

`define ACS_CLK_NS            10
`define ACS_TCONV_INT_NS      1650
`define ACS_TCONV_INT_CYC     (`ACS_TCONV_INT_NS / `ACS_CLK_NS)
`define ACS_EXT_CONV_TICKS    13
`define ACS_EOC_MIN_NS        75
`define ACS_EOC_MAX_NS        180
`define ACS_EOC_CYC           ((`ACS_EOC_MIN_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_START_BUSY_NS     70
`define ACS_FLAG_READ_NS      70
`define ACS_FLAG_EOC_NS       15
`define ACS_READ_GAP_NS       10
`define ACS_WR_SETUP_NS       5
`define ACS_WAKE_EXT_NS       2000
`define ACS_WAKE_INT_NS       6000000
`define ACS_NUM_CH            4
`define ACS_DATA_W            12
`define ACS_SEL_LSB           0
`define ACS_SEL_W             4
`define ACS_FIFO_DEPTH        32

`endif

// ===== shared/acs_pkg.sv
// types shared by the conversion sequencer and its testbench
`include "acs_cfg.svh"
package acs_pkg;
    typedef logic [`ACS_DATA_W-1:0] acs_sample_t;
    typedef acs_sample_t [`ACS_NUM_CH-1:0] acs_samples_t;
    typedef struct packed {
        logic [1:0]  chan;
        acs_sample_t data;
    } acs_result_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_EOC} acs_state_t;
endpackage

// ===== tb/acs_host_model.sv
// host processor model driving the parallel bus strobes
`timescale 1ns/1ps
`default_nettype none
`include "acs_cfg.svh"
module acs_host_model (
    // clock
    input  wire logic                   sys_clk,
    // parallel bus
    output var logic                    chipSelectN,
    output var logic                    readN,
    output var logic                    writeN,
    output var logic [`ACS_DATA_W-1:0]  busIn,
    input  wire logic [`ACS_DATA_W-1:0] busOut
);
    initial begin
        chipSelectN = 1'b1;
        readN = 1'b1;
        writeN = 1'b1;
        busIn = 12'h0a5c;
    end
    task automatic rd(output logic [`ACS_DATA_W-1:0] d);
        @(posedge sys_clk);
        chipSelectN <= 1'b0;
        readN <= 1'b0;
        repeat (3) @(posedge sys_clk);
        d = busOut;
        readN <= 1'b1;
        chipSelectN <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [`ACS_DATA_W-1:0] w);
        @(posedge sys_clk);
        chipSelectN <= 1'b0;
        writeN <= 1'b0;
        busIn <= w;
        repeat (2) @(posedge sys_clk);
        writeN <= 1'b1;
        @(posedge sys_clk);
        chipSelectN <= 1'b1;
        busIn <= ~w;
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acs_cfg.svh"
module testbench;
    import acs_pkg::*;
    localparam int CONV = 165;
    localparam int PULSE = 8;
    logic                   sys_clk, reset, conversionStart, lowPowerInput;
    logic                   useExternalTiming, hwSequenceSelect, busOe, busy, endOfConvN, firstResultFlag;
    logic                   chipSelectN, readN, writeN, ext;
    logic                   externalTimingInput = 1'b0;
    logic [1:0]             tickCnt = 2'd0;
    logic [3:0]             hwChannelSelect, m;
    logic [`ACS_DATA_W-1:0] busIn, busOut;
    logic [`ACS_DATA_W-1:0] expQ[$];
    acs_samples_t           analogSamples;
    int                     mismatches, num_checks, cycles, seed, eocLen, rdCnt, selN;

    acs_seq acs_seq_inst (.sys_clk(sys_clk), .reset(reset), .conversionStart(conversionStart),
        .lowPowerInput(lowPowerInput), .externalTimingInput(externalTimingInput),
        .useExternalTiming(useExternalTiming), .hwSequenceSelect(hwSequenceSelect),
        .hwChannelSelect(hwChannelSelect), .analogSamples(analogSamples), .chipSelectN(chipSelectN),
        .readN(readN), .writeN(writeN), .busIn(busIn), .busOut(busOut), .busOe(busOe), .busy(busy),
        .endOfConvN(endOfConvN), .firstResultFlag(firstResultFlag));
    acs_host_model acs_host_model_inst (.sys_clk(sys_clk), .chipSelectN(chipSelectN), .readN(readN),
        .writeN(writeN), .busIn(busIn), .busOut(busOut));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        tickCnt <= tickCnt + 2'd1;
        externalTimingInput <= tickCnt[1];
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_range(input string what, input int lo, input int hi, input int got);
        num_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            results();
        end
    end
    // pulse width, flag drop and bus enable watcher
    always @(posedge sys_clk) begin
        if (!reset && readN === 1'b0) chk("bus enable", !chipSelectN, busOe);
        if (reset || endOfConvN !== 1'b0) begin
            if (eocLen != 0) chk("eoc width", PULSE, eocLen);
            eocLen = 0;
        end else begin
            if (eocLen == 0) chk("flag at eoc", 0, firstResultFlag);
            eocLen++;
        end
    end
    task automatic start_seq(input logic [3:0] mk, input logic hw, input logic ex);
        acs_samples_t s;
        logic [`ACS_DATA_W-1:0] w;
        s = acs_samples_t'({$random(seed), $random(seed)});
        w = 12'($random(seed));
        w[3:0] = mk;
        if (!hw) acs_host_model_inst.wr(w);
        @(posedge sys_clk);
        analogSamples <= s;
        hwSequenceSelect <= hw;
        hwChannelSelect <= hw ? mk : ~mk;
        useExternalTiming <= ex;
        conversionStart <= 1'b1;
        for (int i = 0; i < 4; i++) if (mk[i]) expQ.push_back(s[i]);
        @(posedge sys_clk);
        conversionStart <= 1'b0;
        rdCnt = 0;
        selN = $countones(mk);
        @(posedge sys_clk);
        chk("busy after start", 1, busy);
    endtask
    task automatic wait_done(input int lo, input int hi);
        int n;
        n = 0;
        while (busy === 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        chk_range("busy length", lo, hi, n);
        repeat (12) @(posedge sys_clk);
    endtask
    task automatic drain(input int cnt, input bit flagOn);
        logic [`ACS_DATA_W-1:0] d;
        repeat (cnt) begin
            acs_host_model_inst.rd(d);
            if (expQ.size() == 0) begin
                chk("empty read", 0, d);
            end else begin
                chk("read data", expQ.pop_front(), d);
                rdCnt++;
                if (flagOn) chk("first flag", rdCnt % selN == 0, firstResultFlag);
            end
        end
    endtask
    initial begin
        seed = 32'hd05d_b7d5;
        reset = 1'b1;
        conversionStart = 1'b0;
        lowPowerInput = 1'b1;
        useExternalTiming = 1'b0;
        hwSequenceSelect = 1'b1;
        hwChannelSelect = 4'hf;
        analogSamples = '0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        lowPowerInput <= 1'b0;
        conversionStart <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("busy asleep", 0, busy);
        conversionStart <= 1'b0;
        lowPowerInput <= 1'b1;
        repeat (200) @(posedge sys_clk);
        $display("test asleep done");
        for (int t = 0; t < 6; t++) begin
            m = (t == 0) ? 4'h1 : (t == 1) ? 4'hf : 4'($random(seed) | 1);
            ext = (t >= 4);
            start_seq(m, t[0], ext);
            if (ext) wait_done(selN * (49 + PULSE) - PULSE, selN * (52 + PULSE) - PULSE);
            else wait_done(selN * (CONV + PULSE) - PULSE, selN * (CONV + PULSE) - PULSE);
            drain(selN + 1, 1);
            $display("test sequence %0d done", t);
        end
        for (int k = 0; k < 9; k++) begin
            start_seq(4'hf, 1'b1, 1'b0);
            if (k < 8) wait_done(4 * (CONV + PULSE) - PULSE, 4 * (CONV + PULSE) - PULSE);
        end
        repeat (800) @(posedge sys_clk);
        chk("busy on full buffer", 1, busy);
        drain(32, 0);
        wait_done(1, 800);
        drain(5, 0);
        $display("test fill done");
        results();
    end
endmodule
`default_nettype wire
